// ==== verilog/phq_pkg.sv ====
// Shared constants, types and carriers for the PCIe PHY helper block.
// Assumes a single 20 MHz core clock and a MAC on the same clock.
package phq_pkg;

  // ==========================================================
  // Register map, byte addresses on the plain register port
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_EQ = 5'h04;
  localparam logic [4:0] REG_MASK = 5'h08;
  localparam logic [4:0] REG_COEF = 5'h0C;
  localparam logic [4:0] REG_STAT = 5'h10;

  // ==========================================================
  // Field positions
  localparam int CTRL_GEN_LSB = 0;
  localparam int EQ_FS_LSB = 0;
  localparam int EQ_LF_LSB = 8;
  localparam int EQ_PREF_LSB = 16;
  localparam int STAT_FSM_LSB = 0;
  localparam int STAT_DONE_BIT = 2;
  localparam int STAT_ALIGN_BIT = 3;
  localparam int STAT_UP_BIT = 4;
  localparam int STAT_FRZ_BIT = 5;
  localparam int STAT_RECOV_LSB = 8;

  // ==========================================================
  // Reset values
  localparam logic [1:0] GEN_RST = 2'h0;
  localparam logic [5:0] FS_RST = 6'h30;
  localparam logic [5:0] LF_RST = 6'h0A;
  localparam logic [3:0] PREF_RST = 4'h5;
  localparam logic [10:0] MASK_RST = 11'h7FF;
  localparam logic [17:0] COEF_RST = 18'h0_0000;

  // ==========================================================
  // Timing: receiver evaluation time before an answer, in cycles
  localparam int EVAL_CYC = 4;

  // ==========================================================
  // Request codes, rates and link training state codes
  localparam logic [1:0] RQ_NONE = 2'h0;
  localparam logic [1:0] RQ_COEF = 2'h1;
  localparam logic [1:0] RQ_PRESET = 2'b10;
  localparam logic [1:0] GEN1 = 2'h0;
  localparam logic [1:0] GEN23 = 2'h1;
  localparam logic [1:0] GEN4 = 2'h2;
  localparam logic [3:0] PRESET_MAX = 4'hA;
  localparam logic [5:0] LT_ZERO = 6'h00;
  localparam logic [5:0] LT_LINK_UP = 6'h10;
  localparam logic [5:0] LT_REC_SPEED = 6'h0C;
  localparam logic [5:0] LT_L1_ENTRY = 6'h1A;
  localparam logic [5:0] LT_L1_IDLE = 6'h1B;
  localparam logic [5:0] LT_LPBK_SLV = 6'h20;
  localparam logic [1:0] FSM_CODE_IDLE = 2'h0;
  localparam logic [1:0] FSM_CODE_LOCK = 2'h1;
  localparam logic [1:0] FSM_CODE_RST = 2'h2;
  localparam logic [1:0] FSM_CODE_SYNC = 2'h3;

  // ==========================================================
  // State machines
  typedef enum logic [3:0] {
    I_IDLE = 4'b0001,
    I_LOCK = 4'b0010,
    I_RST = 4'b0100,
    I_SYNC = 4'b1000
  } phq_init_e;

  typedef enum logic [3:0] {
    E_IDLE = 4'b0001,
    E_EVAL = 4'b0010,
    E_RESP = 4'b0100,
    E_DROP = 4'b1000
  } phq_eq_e;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic [1:0] ctrl;
    logic [3:0] txpreset;
  } phq_rxeq_req_s;

  typedef struct packed {
    logic done;
    logic adapt_done;
    logic [3:0] new_preset;
    logic [17:0] new_coef;
    logic [5:0] fs;
    logic [5:0] lf;
  } phq_rxeq_rsp_s;

  typedef struct packed {
    logic channel_pll_locked;
    logic quad_pll_a_locked;
    logic quad_pll_b_locked;
    logic reset_done;
    logic phy_status;
    logic tx_bypass_aligned;
    logic rx_idle_detect;
  } phq_xcvr_s;

endpackage : phq_pkg

// ==== verilog/phq_cdr_hold.sv ====
// Clock-recovery freeze controller.
// Assumes rx_idle_sync is already synchronised to core_clk.
`timescale 1ns/1ps
`default_nettype none
module phq_cdr_hold
  import phq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic rx_idle_sync,
  input wire logic [5:0] ltssm,
  output logic cdr_freeze
);

  typedef struct packed {
    logic freeze;
  } phq_cdr_st_s;

  phq_cdr_st_s q;
  phq_cdr_st_s d;
  logic in_set;

  // ==========================================================
  // Freeze decision
  // Freeze starts in the listed states and lasts while idle stays high.
  always_comb begin
    in_set = (ltssm == LT_REC_SPEED) || (ltssm == LT_L1_ENTRY) ||
             (ltssm == LT_L1_IDLE) || (ltssm == LT_LPBK_SLV);
    d = q;
    d.freeze = rx_idle_sync && (in_set || q.freeze);
  end

  // Registers the state.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign cdr_freeze = q.freeze;

  a_freeze_start: assert property (@(posedge core_clk) disable iff (!rstn)
    (rx_idle_sync && in_set) |=> cdr_freeze)
    else $error("freeze missed with idle in a freeze state");
  a_freeze_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    (cdr_freeze && rx_idle_sync) |=> cdr_freeze)
    else $error("freeze dropped while idle persisted");
  a_freeze_end: assert property (@(posedge core_clk) disable iff (!rstn)
    (cdr_freeze && !rx_idle_sync) |=> !cdr_freeze)
    else $error("freeze outlived idle");

endmodule : phq_cdr_hold
`default_nettype wire

// ==== verilog/phq_phy_helper.sv ====
// PCIe PHY helper: receiver equalization requester, init sequencer,
// link state tracking and clock-recovery freeze, plus a register port.
// Assumes the MAC runs on core_clk and transceiver status comes from
// another domain, so it is synchronised here.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Equalization requester acts only while equalization phase 2 is active.
// - Report FS, LF and selected preset or coefficients, plus completion status.
// - Preset request code 2'b10; proposing another preset answers done high, adapted low.
// - Accepting the requested preset answers with done and adapted both high.
// - Clock-recovery freeze goes high while receive electrical idle is high.
// - Freeze applies in Recovery.Speed, L1 entry/idle, loopback slave entry; lasts with idle.
// - Link training held at state zero until PLL lock, reset done, PHY status.
// - Lock needed: channel PLL for Gen1, plus quad B Gen2/3, plus quad A Gen4.
// - Init state machine returns to state 00 after its sequence completes.
// - Link state output shows 10 when up; recovery excursions are counted.
// - Transmit buffer-bypass alignment done is raised once alignment completes.
// - Link state output steps from 0x00 to 0x10 on a successful link-up.
module phq_phy_helper
  import phq_pkg::*;
#(
  parameter int EVAL_CYCLES = EVAL_CYC
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [4:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire phq_xcvr_s xcvr_in,
  input wire logic rxeq_phase2,
  input wire phq_rxeq_req_s rxeq_req,
  output phq_rxeq_rsp_s rxeq_rsp,
  input wire logic link_train_permit,
  input wire logic [5:0] mac_ltssm,
  output logic link_train_run,
  output logic [5:0] link_state,
  output logic link_up,
  output logic [1:0] init_fsm_code,
  output logic init_done,
  output logic tx_bypass_aligned,
  output logic cdr_freeze
);

  typedef struct packed {
    logic [6:0] s1;
    logic [6:0] s2;
    phq_init_e i_st;
    logic init_done;
    logic aligned;
    phq_eq_e e_st;
    logic [7:0] cnt;
    logic [1:0] req_ctrl;
    logic [3:0] req_preset;
    logic done;
    logic adapt;
    logic [3:0] new_preset;
    logic [17:0] new_coef;
    logic [1:0] gen;
    logic [5:0] fs;
    logic [5:0] lf;
    logic [3:0] pref;
    logic [10:0] mask;
    logic [17:0] coef;
    logic [5:0] link_state;
    logic [7:0] recov;
    logic [31:0] rdata;
  } phq_main_st_s;

  localparam phq_main_st_s ST_RST = '{
    i_st: I_LOCK,
    e_st: E_IDLE,
    gen: GEN_RST,
    fs: FS_RST,
    lf: LF_RST,
    pref: PREF_RST,
    mask: MASK_RST,
    coef: COEF_RST,
    default: '0
  };
  localparam logic [7:0] EVAL_LAST = 8'(EVAL_CYCLES - 1);

  phq_main_st_s q;
  phq_main_st_s d;
  phq_xcvr_s xs;
  logic lock_ok;
  logic accept;
  logic [31:0] stat_word;

  // ==========================================================
  // Synchronised transceiver view
  // Only the second stage is read; the first feeds the second alone.
  assign xs = phq_xcvr_s'(q.s2);

  // Lock set required by the configured top rate.
  always_comb begin
    unique case (q.gen)
      GEN1: lock_ok = xs.channel_pll_locked;
      GEN23: lock_ok = xs.channel_pll_locked && xs.quad_pll_b_locked;
      GEN4: lock_ok = xs.channel_pll_locked && xs.quad_pll_a_locked;
      default: lock_ok = 1'b0;
    endcase
  end

  // A requested preset is taken when legal and enabled in the mask.
  assign accept = (q.req_preset <= PRESET_MAX) && q.mask[q.req_preset[3:0]];

  // Status word assembled from live state.
  always_comb begin
    stat_word = '0;
    stat_word[STAT_FSM_LSB +: 2] = init_fsm_code;
    stat_word[STAT_DONE_BIT] = q.init_done;
    stat_word[STAT_ALIGN_BIT] = q.aligned;
    stat_word[STAT_UP_BIT] = link_up;
    stat_word[STAT_FRZ_BIT] = cdr_freeze;
    stat_word[STAT_RECOV_LSB +: 8] = q.recov;
  end

  // ==========================================================
  // Next-state logic for the whole block
  always_comb begin
    d = q;
    d.s1 = xcvr_in;
    d.s2 = q.s1;
    d.done = 1'b0;
    d.rdata = '0;

    // Register writes; unmapped addresses are ignored.
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRL: d.gen = reg_wdata[CTRL_GEN_LSB +: 2];
        REG_EQ: begin
          d.fs = reg_wdata[EQ_FS_LSB +: 6];
          d.lf = reg_wdata[EQ_LF_LSB +: 6];
          d.pref = reg_wdata[EQ_PREF_LSB +: 4];
        end
        REG_MASK: d.mask = reg_wdata[10:0];
        REG_COEF: d.coef = reg_wdata[17:0];
        default: d.gen = q.gen;
      endcase
    end

    // Register reads answer in the next cycle; unmapped reads give zero.
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRL: d.rdata[CTRL_GEN_LSB +: 2] = q.gen;
        REG_EQ: begin
          d.rdata[EQ_FS_LSB +: 6] = q.fs;
          d.rdata[EQ_LF_LSB +: 6] = q.lf;
          d.rdata[EQ_PREF_LSB +: 4] = q.pref;
        end
        REG_MASK: d.rdata[10:0] = q.mask;
        REG_COEF: d.rdata[17:0] = q.coef;
        REG_STAT: d.rdata = stat_word;
        default: d.rdata = '0;
      endcase
    end

    // Init sequencer: lock, then reset completion, then bypass alignment.
    unique case (q.i_st)
      I_LOCK: begin
        d.init_done = 1'b0;
        if (lock_ok) begin
          d.i_st = I_RST;
        end
      end
      I_RST: begin
        if (!lock_ok) begin
          d.i_st = I_LOCK;
        end else if (xs.reset_done && xs.phy_status) begin
          d.i_st = I_SYNC;
        end
      end
      I_SYNC: begin
        if (!lock_ok) begin
          d.i_st = I_LOCK;
        end else if (xs.tx_bypass_aligned) begin
          d.i_st = I_IDLE;
          d.init_done = 1'b1;
        end
      end
      I_IDLE: begin
        if (!lock_ok) begin
          d.i_st = I_LOCK;
          d.init_done = 1'b0;
        end
      end
    endcase
    d.aligned = xs.tx_bypass_aligned;

    // Link state follows the MAC only once training may run.
    d.link_state = (q.init_done && link_train_permit) ? mac_ltssm : LT_ZERO;
    if ((q.link_state == LT_LINK_UP) && (d.link_state != LT_LINK_UP) && (q.recov != 8'hFF)) begin
      d.recov = q.recov + 8'h01;
    end

    // Receiver equalization requester.
    unique case (q.e_st)
      E_IDLE: begin
        if (rxeq_phase2 && (rxeq_req.ctrl != RQ_NONE)) begin
          d.e_st = E_EVAL;
          d.req_ctrl = rxeq_req.ctrl;
          d.req_preset = rxeq_req.txpreset;
          d.cnt = '0;
        end
      end
      E_EVAL: begin
        if (!rxeq_phase2) begin
          d.e_st = E_IDLE;
        end else if (q.cnt == EVAL_LAST) begin
          d.e_st = E_RESP;
          d.done = 1'b1;
          if (q.req_ctrl == RQ_PRESET) begin
            d.adapt = accept;
            d.new_preset = accept ? q.req_preset : q.pref;
          end else begin
            d.adapt = 1'b1;
            d.new_coef = q.coef;
          end
        end else begin
          d.cnt = q.cnt + 8'h01;
        end
      end
      E_RESP: begin
        d.adapt = 1'b0;
        d.e_st = E_DROP;
      end
      E_DROP: begin
        if (rxeq_req.ctrl == RQ_NONE) begin
          d.e_st = E_IDLE;
        end
      end
    endcase
  end

  // Registers all state; synchronous reset.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // ==========================================================
  // Clock-recovery freeze
  phq_cdr_hold u_cdr_hold (
    .core_clk(core_clk),
    .rstn(rstn),
    .rx_idle_sync(xs.rx_idle_detect),
    .ltssm(q.link_state),
    .cdr_freeze(cdr_freeze)
  );

  // ==========================================================
  // Outputs
  // Init state code shows 00 once the sequence has completed.
  always_comb begin
    unique case (q.i_st)
      I_IDLE: init_fsm_code = FSM_CODE_IDLE;
      I_LOCK: init_fsm_code = FSM_CODE_LOCK;
      I_RST: init_fsm_code = FSM_CODE_RST;
      I_SYNC: init_fsm_code = FSM_CODE_SYNC;
      default: init_fsm_code = FSM_CODE_LOCK;
    endcase
  end

  assign rxeq_rsp = '{
    done: q.done,
    adapt_done: q.adapt,
    new_preset: q.new_preset,
    new_coef: q.new_coef,
    fs: q.fs,
    lf: q.lf
  };
  assign reg_rdata = q.rdata;
  assign link_state = q.link_state;
  assign link_up = (q.link_state == LT_LINK_UP);
  assign link_train_run = q.init_done && link_train_permit;
  assign init_done = q.init_done;
  assign tx_bypass_aligned = q.aligned;

  // ==========================================================
  // Checks
  a_phase2_only: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.e_st == E_IDLE && !rxeq_phase2) |=> (q.e_st == E_IDLE))
    else $error("requester started outside phase 2");
  a_propose_new: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.e_st == E_EVAL && rxeq_phase2 && q.cnt == EVAL_LAST && q.req_ctrl == RQ_PRESET && !accept)
    |=> (rxeq_rsp.done && !rxeq_rsp.adapt_done && rxeq_rsp.new_preset == $past(q.pref)))
    else $error("proposal answer wrong");
  a_accept_both: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.e_st == E_EVAL && rxeq_phase2 && q.cnt == EVAL_LAST && q.req_ctrl == RQ_PRESET && accept)
    |=> (rxeq_rsp.done && rxeq_rsp.adapt_done))
    else $error("accept answer wrong");
  a_done_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
    rxeq_rsp.done |=> (!rxeq_rsp.done && !rxeq_rsp.adapt_done) ##1 !rxeq_rsp.done)
    else $error("done not a single pulse");
  a_hold_zero: assert property (@(posedge core_clk) disable iff (!rstn)
    (!q.init_done || !link_train_permit) |=> (link_state == LT_ZERO))
    else $error("link state left zero before init");
  a_gen4_lock: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.i_st == I_LOCK && q.gen == GEN4 && !xs.quad_pll_a_locked) |=> (q.i_st == I_LOCK))
    else $error("left lock wait without quad A lock");
  a_back_idle: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.i_st == I_SYNC && lock_ok && xs.tx_bypass_aligned)
    |=> (init_fsm_code == FSM_CODE_IDLE && init_done))
    else $error("init did not return to 00");
  a_recov_count: assert property (@(posedge core_clk) disable iff (!rstn)
    (link_state == LT_LINK_UP && q.recov != 8'hFF && q.init_done && link_train_permit &&
     mac_ltssm != LT_LINK_UP) |=> (q.recov == $past(q.recov) + 8'h01))
    else $error("recovery excursion not counted");
  a_coef_answer: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.e_st == E_EVAL && rxeq_phase2 && q.cnt == EVAL_LAST && q.req_ctrl != RQ_PRESET)
    |=> (rxeq_rsp.done && rxeq_rsp.adapt_done && rxeq_rsp.new_coef == $past(q.coef)))
    else $error("coefficient answer wrong");
  a_abort_eval: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.e_st == E_EVAL && !rxeq_phase2) |=> (q.e_st == E_IDLE && !rxeq_rsp.done))
    else $error("evaluation not dropped when phase 2 ended");
  a_chan_lock: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.i_st == I_LOCK && !xs.channel_pll_locked) |=> (q.i_st == I_LOCK))
    else $error("left lock wait without channel lock");
  a_gen23_lock: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.i_st == I_LOCK && q.gen == GEN23 && !xs.quad_pll_b_locked) |=> (q.i_st == I_LOCK))
    else $error("left lock wait without quad B lock");
  a_lock_loss: assert property (@(posedge core_clk) disable iff (!rstn)
    !lock_ok |=> (init_fsm_code == FSM_CODE_LOCK && !init_done))
    else $error("lock loss did not restart the sequence");
  a_idle_code: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.i_st == I_IDLE) |-> (init_fsm_code == FSM_CODE_IDLE && init_done))
    else $error("finished sequence without code 00");
  a_link_follow: assert property (@(posedge core_clk) disable iff (!rstn)
    (q.init_done && link_train_permit) |=> (link_state == $past(mac_ltssm)))
    else $error("link state did not follow the MAC");
  a_align_copy: assert property (@(posedge core_clk) disable iff (!rstn)
    xs.tx_bypass_aligned |=> tx_bypass_aligned)
    else $error("alignment done not raised");

endmodule : phq_phy_helper
`default_nettype wire

// ==== tb/phq_mac_xcvr_model.sv ====
// Model of the MAC equalization requester and the transceiver status pins.
// Assumes it shares core_clk with the helper block and is steered by the bench.
`timescale 1ns/1ps
`default_nettype none
module phq_mac_xcvr_model
  import phq_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic go,
  input wire logic go_p2,
  input wire phq_rxeq_req_s go_req,
  input wire logic [5:0] xc,
  input wire logic cut,
  input wire phq_rxeq_rsp_s rxeq_rsp,
  output logic rxeq_phase2,
  output phq_rxeq_req_s rxeq_req,
  output phq_xcvr_s xcvr_in,
  output logic busy
);
  // ==========================================================
  // Transceiver levels
  logic [4:0] wait_q;

  // PHY status is wired to reset completion so the init sequence can finish.
  assign xcvr_in = '{xc[5], xc[4], xc[3], xc[2], xc[2], xc[1], xc[0]};

  // ==========================================================
  // Equalization request handshake
  // A request is held until done, or a give-up count if never answered.
  // With cut high, phase 2 ends one cycle after the helper takes the request.
  // A released preset field shows the inverse of its last value.
  always @(posedge core_clk) begin
    if (!rstn) begin
      busy <= 1'b0;
      rxeq_phase2 <= 1'b0;
      rxeq_req <= '{RQ_NONE, 4'h0};
      wait_q <= 5'h00;
    end else if (!busy && go) begin
      busy <= 1'b1;
      rxeq_phase2 <= go_p2 || cut;
      rxeq_req <= go_req;
      wait_q <= 5'h00;
    end else if (busy && (rxeq_rsp.done || wait_q == 5'h1F)) begin
      busy <= 1'b0;
      rxeq_phase2 <= 1'b0;
      rxeq_req <= '{RQ_NONE, ~rxeq_req.txpreset};
    end else if (busy && cut && wait_q == 5'h01) begin
      rxeq_phase2 <= 1'b0;
      wait_q <= wait_q + 5'h01;
    end else begin
      wait_q <= wait_q + 5'h01;
    end
  end
endmodule : phq_mac_xcvr_model
`default_nettype wire

// ==== tb/phq_phy_helper_tb_top.sv ====
// Self-checking bench for the PCIe PHY helper block.
// Assumes one 20 MHz clock and the model of the MAC and transceiver beside it.
`timescale 1ns/1ps
`default_nettype none
module phq_phy_helper_tb_top;
  import phq_pkg::*;
  typedef struct packed {logic coef; logic adapt; logic [3:0] pre; logic [17:0] cf;} phq_tb_eq_s;
  localparam int EVAL_P = 3;
  logic core_clk, rstn, reg_wr, reg_rd, go, go_p2, cut, rxeq_phase2, permit, busy, rd_d, done_d;
  logic link_train_run, link_up, init_done, tx_bypass_aligned, cdr_freeze;
  logic [4:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rd_q[$];
  logic [5:0] xc, mac_ltssm, link_state, fs_v, lf_v;
  logic [1:0] init_fsm_code;
  logic [10:0] mask_v;
  logic [3:0] pref_v;
  logic [17:0] coef_v;
  phq_rxeq_req_s go_req, rxeq_req;
  phq_rxeq_rsp_s rxeq_rsp;
  phq_xcvr_s xcvr_in;
  phq_tb_eq_s eq_q[$], eq_e;
  int mismatches, cmp_count, cyc, eq_cyc, n, g;
  logic [2:0] bad[3], good[3];
  logic [5:0] frz_st[4];

  // ==========================================================
  // Design, partner and clock
  phq_phy_helper #(.EVAL_CYCLES(EVAL_P)) dut (.core_clk(core_clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xcvr_in(xcvr_in),
    .rxeq_phase2(rxeq_phase2), .rxeq_req(rxeq_req), .rxeq_rsp(rxeq_rsp), .link_train_permit(permit),
    .mac_ltssm(mac_ltssm), .link_train_run(link_train_run), .link_state(link_state), .link_up(link_up),
    .init_fsm_code(init_fsm_code), .init_done(init_done), .tx_bypass_aligned(tx_bypass_aligned),
    .cdr_freeze(cdr_freeze));
  phq_mac_xcvr_model partner (.core_clk(core_clk), .rstn(rstn), .go(go), .go_p2(go_p2), .go_req(go_req),
    .xc(xc), .cut(cut), .rxeq_rsp(rxeq_rsp), .rxeq_phase2(rxeq_phase2), .rxeq_req(rxeq_req), .xcvr_in(xcvr_in),
    .busy(busy));

  // The clock toggles every 25 ns, a period of 50 ns.
  always #25 core_clk = ~core_clk;

  // ==========================================================
  // Tasks
  // Compares one value and reports a mismatch at once.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // One write cycle, then an idle edge so strobes never collide.
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // One read cycle; the expected word is noted for the monitor.
  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  // Issues one equalization request through the partner and notes the answer.
  task automatic eq_req(input logic [1:0] c, input logic [3:0] p, input logic p2);
    phq_tb_eq_s e;
    e.coef = (c == RQ_COEF);
    e.adapt = e.coef || (p <= PRESET_MAX && mask_v[p]);
    e.pre = e.adapt ? p : pref_v;
    e.cf = coef_v;
    if (p2) eq_q.push_back(e);
    go_req <= '{c, p};
    go_p2 <= p2;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    for (int k = 0; k < 60 && busy; k++) @(posedge core_clk);
    repeat (2) @(posedge core_clk);
  endtask : eq_req

  // ==========================================================
  // Monitor: read data, equalization answers, pulse length and a hang limit.
  always @(posedge core_clk) begin
    if (rd_d) check(reg_rdata, rd_q.pop_front());
    rd_d <= reg_rd;
    if (rxeq_rsp.done === 1'b1) begin
      if (eq_q.size() == 0) begin
        check(1, 0);
      end else begin
        eq_e = eq_q.pop_front();
        check(eq_cyc >= EVAL_P + 1 && eq_cyc <= EVAL_P + 2, 1);
        if (eq_e.coef) check({rxeq_rsp.adapt_done, rxeq_rsp.new_coef}, {1'b1, eq_e.cf});
        else check({rxeq_rsp.adapt_done, rxeq_rsp.new_preset}, {eq_e.adapt, eq_e.pre});
      end
    end
    if (done_d) check({rxeq_rsp.done, rxeq_rsp.adapt_done}, 0);
    done_d <= rxeq_rsp.done;
    eq_cyc <= (rxeq_phase2 && rxeq_req.ctrl != RQ_NONE) ? eq_cyc + 1 : 0;
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      give_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    core_clk = 0; rstn = 0; reg_wr = 0; reg_rd = 0; reg_addr = 0; reg_wdata = 0; go = 0; go_p2 = 0; cut = 0;
    go_req = '0; xc = 6'h00; permit = 1'b1; mac_ltssm = LT_ZERO; rd_d = 0; done_d = 0; eq_cyc = 0;
    bad = '{3'b011, 3'b110, 3'b101};
    good = '{3'b100, 3'b101, 3'b110};
    frz_st = '{LT_REC_SPEED, LT_L1_ENTRY, LT_L1_IDLE, LT_LPBK_SLV};
    void'($urandom(46));
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    // Reset values, then a write and a read at an unmapped place.
    check({rxeq_rsp.fs, rxeq_rsp.lf}, {FS_RST, LF_RST});
    rd(REG_CTRL, 32'h0000_0000);
    rd(REG_EQ, 32'h0005_0A30);
    rd(REG_MASK, 32'h0000_07FF);
    rd(REG_COEF, 32'h0000_0000);
    wr(5'h14, 32'hFFFF_FFFF);
    rd(5'h14, 32'h0000_0000);
    // Init sequencer per rate: the wrong PLL set keeps it waiting for lock.
    for (g = 0; g < 3; g++) begin
      wr(REG_CTRL, g);
      xc <= 6'h00;
      repeat (6) @(posedge core_clk);
      check({init_fsm_code, init_done, link_state}, {FSM_CODE_LOCK, 1'b0, LT_ZERO});
      xc <= {bad[g], 3'b110};
      repeat (10) @(posedge core_clk);
      check({init_fsm_code, init_done}, {FSM_CODE_LOCK, 1'b0});
      xc <= {good[g], 3'b110};
      for (n = 0; n < 20 && init_done !== 1'b1; n++) @(posedge core_clk);
      check({init_fsm_code, init_done, tx_bypass_aligned}, {FSM_CODE_IDLE, 2'b11});
    end
    // Link training walk up to link-up, one recovery excursion, permit removed.
    for (n = 0; n <= 16; n += 2) begin
      mac_ltssm <= 6'(n);
      repeat (2) @(posedge core_clk);
      check(link_state, n);
    end
    check({link_up, link_train_run}, 2'b11);
    mac_ltssm <= LT_REC_SPEED;
    repeat (2) @(posedge core_clk);
    mac_ltssm <= LT_LINK_UP;
    repeat (2) @(posedge core_clk);
    rd(REG_STAT, 32'h0000_011C);
    permit <= 1'b0;
    repeat (2) @(posedge core_clk);
    check({link_train_run, link_state}, 0);
    permit <= 1'b1;
    // Clock-recovery freeze in each listed state, lasting while idle stays.
    for (n = 0; n < 4; n++) begin
      mac_ltssm <= frz_st[n];
      repeat (2) @(posedge core_clk);
      xc <= {xc[5:1], 1'b1};
      repeat (5) @(posedge core_clk);
      check(cdr_freeze, 1);
      mac_ltssm <= LT_LINK_UP;
      repeat (3) @(posedge core_clk);
      check(cdr_freeze, 1);
      xc <= {xc[5:1], 1'b0};
      repeat (5) @(posedge core_clk);
      check(cdr_freeze, 0);
    end
    // Equalization: new settings, a request outside phase 2, one cut short, then a mix.
    mask_v = 11'($urandom());
    pref_v = 4'($urandom_range(0, 10));
    coef_v = 18'($urandom());
    fs_v = 6'($urandom());
    lf_v = 6'($urandom());
    wr(REG_MASK, {21'h0, mask_v});
    wr(REG_EQ, {12'h000, pref_v, 2'b00, lf_v, 2'b00, fs_v});
    wr(REG_COEF, {14'h0000, coef_v});
    rd(REG_EQ, {12'h000, pref_v, 2'b00, lf_v, 2'b00, fs_v});
    check({rxeq_rsp.fs, rxeq_rsp.lf}, {fs_v, lf_v});
    eq_req(RQ_PRESET, 4'h3, 1'b0);
    cut <= 1'b1;
    eq_req(RQ_PRESET, 4'h6, 1'b0);
    cut <= 1'b0;
    eq_req(RQ_PRESET, PRESET_MAX, 1'b1);
    eq_req(RQ_PRESET, 4'hB, 1'b1);
    for (n = 0; n < 12; n++) begin
      eq_req(($urandom_range(0, 2) == 0) ? RQ_COEF : RQ_PRESET, 4'($urandom_range(0, 15)), 1'b1);
    end
    check(eq_q.size(), 0);
    give_verdict();
  end
endmodule : phq_phy_helper_tb_top
`default_nettype wire
